/* File: hw/bpc_pkg.sv */
// constants, register layout and state types of the port bypass control channels 1 to 3
package bpc_pkg;

   localparam int BPC_CHANNELS = 3;
   localparam int BPC_PINS = 8;

   localparam logic [7:0] BPC_ADDR_CH1 = 8'h21;
   localparam logic [7:0] BPC_ADDR_CH2 = 8'h22;
   localparam logic [7:0] BPC_ADDR_CH3 = 8'h23;

   localparam int BPC_BIT_ENABLE = 7;
   localparam int BPC_BIT_IRQ_EN = 6;
   localparam int BPC_BIT_FORCE = 1;
   localparam int BPC_BIT_DETECT = 0;

   // pin of port 3 used by channel index c (0 for channel 1)
   localparam int BPC_DET_PIN_BASE = 2;
   localparam int BPC_FORCE_PIN_BASE = 3;

   localparam logic BPC_RST_ENABLE = 1'b0;
   localparam logic BPC_RST_IRQ_EN = 1'b0;
   localparam logic BPC_RST_FORCE = 1'b1;
   localparam logic [7:0] BPC_RST_SOURCE = 8'h00;
   localparam logic [7:0] BPC_RST_PIN_LEVEL = 8'hFF;

   localparam int BPC_CLK_PERIOD_NS = 5;
   localparam int BPC_LOSS_LATENCY_NS = 400;
   localparam int BPC_LOSS_LATENCY_CYC = BPC_LOSS_LATENCY_NS / BPC_CLK_PERIOD_NS;
   // samples a pin must hold a new level before the filter accepts it
   localparam logic [2:0] BPC_FILTER_CYC = 3'h4;
   // sync 2 + filter + register + output stays well under the loss latency
   localparam int BPC_PATH_CYC = 2 + int'(BPC_FILTER_CYC) + 2;

   typedef struct packed {
      logic enable;
      logic irq_en;
      logic force_bit;
   } bpc_chan_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } bpc_reg_req_t;

   typedef struct packed {
      bpc_chan_t [BPC_CHANNELS-1:0] chan;
      logic [BPC_PINS-1:0] sync1;
      logic [BPC_PINS-1:0] sync2;
      logic [BPC_PINS-1:0] filt;
      logic [BPC_PINS-1:0][2:0] filt_cnt;
      logic [BPC_CHANNELS-1:0] det_prev;
      logic [BPC_CHANNELS-1:0] pending;
      logic [7:0] source;
      logic [7:0] rdata;
      logic [BPC_PINS-1:0] pin_out;
      logic [BPC_PINS-1:0] pin_oe;
      logic irq_n;
   } bpc_state_t;

   localparam bpc_chan_t BPC_CHAN_RST = '{enable: BPC_RST_ENABLE, irq_en: BPC_RST_IRQ_EN,
                                         force_bit: BPC_RST_FORCE};

   localparam bpc_state_t BPC_STATE_RST = '{
      chan: {BPC_CHANNELS{BPC_CHAN_RST}},
      sync1: BPC_RST_PIN_LEVEL,
      sync2: BPC_RST_PIN_LEVEL,
      filt: BPC_RST_PIN_LEVEL,
      filt_cnt: '0,
      det_prev: {BPC_CHANNELS{1'b1}},
      pending: '0,
      source: BPC_RST_SOURCE,
      rdata: 8'h00,
      pin_out: 8'h00,
      pin_oe: 8'h00,
      irq_n: 1'b1
   };

endpackage

/* File: hw/bpc_port_bypass.sv */
// port bypass control channels 1 to 3 on port 3 pins, with register port and interrupt
`timescale 1ns/100ps
`default_nettype none
module bpc_port_bypass
   import bpc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire bpc_reg_req_t reg_req_i,
   input wire logic irq_ack_i,
   input wire logic [7:0] pin_in_i,
   input wire logic [7:0] gpio_out_i,
   input wire logic [7:0] gpio_oe_i,
   output logic [7:0] reg_rdata_o,
   output logic [7:0] pin_out_o,
   output logic [7:0] pin_oe_o,
   output logic irq_n_o,
   output logic [7:0] irq_source_o
);

   bpc_state_t st;
   bpc_state_t next_st;

   function automatic logic [7:0] chan_addr(input int c);
      case (c)
         0: chan_addr = BPC_ADDR_CH1;
         1: chan_addr = BPC_ADDR_CH2;
         default: chan_addr = BPC_ADDR_CH3;
      endcase
   endfunction

   function automatic int det_pin(input int c);
      det_pin = BPC_DET_PIN_BASE + 2 * c;
   endfunction

   function automatic int force_pin(input int c);
      force_pin = BPC_FORCE_PIN_BASE + 2 * c;
   endfunction

   always_comb begin
      logic [BPC_CHANNELS-1:0] det_edge;
      logic [BPC_CHANNELS-1:0] new_irq;
      logic [7:0] rd_val;
      logic src_loaded;
      next_st = st;
      det_edge = '0;
      new_irq = '0;
      rd_val = 8'h00;
      src_loaded = 1'b0;

      // two-flop synchroniser then level filter on every pin
      next_st.sync1 = pin_in_i;
      next_st.sync2 = st.sync1;
      for (int p = 0; p < BPC_PINS; p++) begin
         if (st.sync2[p] == st.filt[p]) begin
            next_st.filt_cnt[p] = 3'h0;
         end else if (st.filt_cnt[p] == BPC_FILTER_CYC - 3'h1) begin
            next_st.filt[p] = st.sync2[p];
            next_st.filt_cnt[p] = 3'h0;
         end else begin
            next_st.filt_cnt[p] = st.filt_cnt[p] + 3'h1;
         end
      end

      for (int c = 0; c < BPC_CHANNELS; c++) begin
         // register write; bits 5..2 and the detect bit are not stored
         if (reg_req_i.wr && reg_req_i.addr == chan_addr(c)) begin
            next_st.chan[c].enable = reg_req_i.wdata[BPC_BIT_ENABLE];
            next_st.chan[c].irq_en = reg_req_i.wdata[BPC_BIT_IRQ_EN];
            next_st.chan[c].force_bit = reg_req_i.wdata[BPC_BIT_FORCE];
         end
         // loss of signal beats a write in the same cycle
         if (next_st.chan[c].enable && !st.filt[det_pin(c)]) begin
            next_st.chan[c].force_bit = 1'b0;
         end

         next_st.det_prev[c] = st.filt[det_pin(c)];
         det_edge[c] = st.filt[det_pin(c)] ^ st.det_prev[c];
         new_irq[c] = det_edge[c] && st.chan[c].enable && st.chan[c].irq_en;
      end

      // acknowledge clears, but an event in the same cycle stays pending
      next_st.pending = (irq_ack_i ? '0 : st.pending) | new_irq;
      for (int c = 0; c < BPC_CHANNELS; c++) begin
         if (new_irq[c] && !src_loaded) begin
            next_st.source = chan_addr(c);
            src_loaded = 1'b1;
         end
      end
      next_st.irq_n = ~|next_st.pending;

      // pin mux: enabled channels take their pins, the rest pass the port setup
      next_st.pin_out = gpio_out_i;
      next_st.pin_oe = gpio_oe_i;
      for (int c = 0; c < BPC_CHANNELS; c++) begin
         if (next_st.chan[c].enable) begin
            next_st.pin_out[force_pin(c)] = next_st.chan[c].force_bit;
            next_st.pin_oe[force_pin(c)] = 1'b1;
            next_st.pin_out[det_pin(c)] = 1'b0;
            next_st.pin_oe[det_pin(c)] = 1'b0;
         end
      end

      // read path: detect bit shows the filtered level, force bit the register when enabled, else the filtered pin
      for (int c = 0; c < BPC_CHANNELS; c++) begin
         if (reg_req_i.addr == chan_addr(c)) begin
            rd_val[BPC_BIT_ENABLE] = st.chan[c].enable;
            rd_val[BPC_BIT_IRQ_EN] = st.chan[c].irq_en;
            rd_val[BPC_BIT_FORCE] = st.chan[c].enable ? st.chan[c].force_bit
                                                      : st.filt[force_pin(c)];
            rd_val[BPC_BIT_DETECT] = st.filt[det_pin(c)];
         end
      end
      if (reg_req_i.rd) begin
         next_st.rdata = rd_val;
      end
   end

   // reset leaves every pin undriven so the pad pull-ups set the level
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= BPC_STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata_o = st.rdata;
   assign pin_out_o = st.pin_out;
   assign pin_oe_o = st.pin_oe;
   assign irq_n_o = st.irq_n;
   assign irq_source_o = st.source;

endmodule
`default_nettype wire

/* File: test/bpc_port_bypass_asserts.sv */
// checker for the bypass control port
`timescale 1ns/100ps
`default_nettype none
module bpc_port_bypass_asserts
   import bpc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire bpc_reg_req_t reg_req_i,
   input wire logic irq_ack_i,
   input wire logic [7:0] pin_in_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] pin_out_o,
   input wire logic [7:0] pin_oe_o,
   input wire logic irq_n_o,
   input wire logic [7:0] irq_source_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_own(a, f);
      reg_req_i.wr && reg_req_i.addr == a && reg_req_i.wdata[7]
         |-> ##[1:2] pin_oe_o[f] && !pin_oe_o[f-1];
   endproperty
   // detect lost for a full filter span while the force pin is owned
   sequence s_loss;
      pin_oe_o[3] && $fell(pin_in_i[2]) ##1 (!pin_in_i[2])[*8];
   endsequence
   a_ch1_pins_owned: assert property (p_own(BPC_ADDR_CH1, 3))
      else $error("ch1 pins not owned");
   a_ch2_pins_owned: assert property (p_own(BPC_ADDR_CH2, 5))
      else $error("ch2 pins not owned");
   a_ch3_pins_owned: assert property (p_own(BPC_ADDR_CH3, 7))
      else $error("ch3 pins not owned");
   a_src_addr_valid: assert property (!irq_n_o |-> irq_source_o inside {[8'h21:8'h23]})
      else $error("bad irq source");
   a_irq_held: assert property (!irq_n_o && !irq_ack_i |=> !irq_n_o)
      else $error("irq dropped without ack");
   a_rsvd_bits_zero: assert property (reg_req_i.rd |=> reg_rdata_o[5:2] == 4'h0)
      else $error("reserved bits set");
   a_unmapped_zero: assert property (reg_req_i.rd && !(reg_req_i.addr inside {[8'h21:8'h23]})
      |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_loss_clears: assert property (s_loss |-> ##[0:72] (!pin_out_o[3] || !pin_oe_o[3]))
      else $error("force not cleared in time");
endmodule
bind bpc_port_bypass bpc_port_bypass_asserts u_chk (.clock_i, .rst_n_i, .reg_req_i,
   .irq_ack_i, .pin_in_i, .reg_rdata_o, .pin_out_o, .pin_oe_o, .irq_n_o, .irq_source_o);
`default_nettype wire

/* File: test/bpc_sdu_model.sv */
// far-side model: signal detect units and pad pulls of port 3
`timescale 1ns/100ps
`default_nettype none
module bpc_detect_model
(
   input wire logic [2:0] sig_i,
   input wire logic [7:0] pin_out_i,
   input wire logic [7:0] pin_oe_i,
   output logic [7:0] pin_in_o,
   output logic [2:0] bypass_o
);
   // channel 2 strapped to bypass by an external pull-down
   localparam logic [2:0] PULL_DN = 3'h2;
   always_comb begin
      pin_in_o = pin_oe_i & pin_out_i | ~pin_oe_i;
      for (int c = 0; c < 3; c++) begin
         if (!pin_oe_i[3+2*c] && PULL_DN[c]) pin_in_o[3+2*c] = 1'b0;
         if (!pin_oe_i[2+2*c]) pin_in_o[2+2*c] = sig_i[c];
         bypass_o[c] = !pin_in_o[3+2*c];
      end
   end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the bypass control channels
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import bpc_pkg::*;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic irq_ack_i = 1'b0;
   logic [2:0] sig = 3'h7;
   logic [7:0] gpio_out_i = 8'h02;
   logic [7:0] gpio_oe_i = 8'h03;
   bpc_reg_req_t reg_req_i = '0;
   logic [7:0] pin_in_i, reg_rdata_o, pin_out_o, pin_oe_o, irq_source_o;
   logic irq_n_o;
   logic [2:0] bypass;
   int miscompares = 0;
   int cmp_count = 0;
   always #2.5 clock_i = ~clock_i;
   bpc_port_bypass dut (.clock_i, .rst_n_i, .reg_req_i, .irq_ack_i, .pin_in_i, .gpio_out_i,
      .gpio_oe_i, .reg_rdata_o, .pin_out_o, .pin_oe_o, .irq_n_o, .irq_source_o);
   bpc_detect_model far (.sig_i(sig), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
      .pin_in_o(pin_in_i), .bypass_o(bypass));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i) reg_req_i <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clock_i) reg_req_i <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock_i) reg_req_i <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clock_i) reg_req_i <= '0;
      @(negedge clock_i) chk(reg_rdata_o, exp);
   endtask
   // drop one detect line, wait the full loss latency, then acknowledge
   task automatic loss(input int c, input logic irq, input logic [7:0] src);
      @(posedge clock_i) sig[c] <= 1'b0;
      repeat (80) @(posedge clock_i);
      @(negedge clock_i) chk({7'h0, pin_out_o[3+2*c]}, 8'h00);
      chk({7'h0, irq_n_o}, {7'h0, !irq});
      if (irq) chk(irq_source_o, src);
      @(posedge clock_i) irq_ack_i <= 1'b1;
      @(posedge clock_i) irq_ack_i <= 1'b0;
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (10) @(posedge clock_i);
      rd(8'h21, 8'h03);
      rd(8'h22, 8'h01);
      rd(8'h24, 8'h00);
      wr(8'h21, 8'h40);
      repeat (3) @(posedge clock_i);
      @(negedge clock_i) chk(pin_oe_o, 8'h03);
      rd(8'h21, 8'h43);
      wr(8'h21, 8'hBE);
      wr(8'h22, 8'hC0);
      wr(8'h23, 8'hC2);
      repeat (3) @(posedge clock_i);
      @(negedge clock_i) chk(pin_oe_o, 8'hAB);
      chk(pin_out_o, 8'h8A);
      chk({5'h0, bypass}, 8'h02);
      rd(8'h21, 8'h83);
      // toggle force on channel 3 while its detect line stays high
      wr(8'h23, 8'hC0);
      repeat (3) @(posedge clock_i);
      @(negedge clock_i) chk(pin_out_o, 8'h0A);
      wr(8'h23, 8'hC2);
      rd(8'h23, 8'hC3);
      loss(0, 1'b0, 8'h00);
      // force write of 1 is lost while the filtered detect line is low
      wr(8'h21, 8'h82);
      rd(8'h21, 8'h80);
      loss(1, 1'b1, BPC_ADDR_CH2);
      loss(2, 1'b1, BPC_ADDR_CH3);
      rd(8'h23, 8'hC0);
      // a rising detect edge must interrupt as well
      @(posedge clock_i) sig[2] <= 1'b1;
      repeat (20) @(posedge clock_i);
      @(negedge clock_i) chk({7'h0, irq_n_o}, 8'h00);
      chk(irq_source_o, BPC_ADDR_CH3);
      @(posedge clock_i) irq_ack_i <= 1'b1;
      @(posedge clock_i) irq_ack_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      @(negedge clock_i) chk({7'h0, irq_n_o}, 8'h01);
      test_done;
   end
endmodule
`default_nettype wire
